// ---- shared/timer_core_defines.svh ----
// constants for the timer module common core: byte addresses, field codes, prescaler taps
`ifndef TIMER_CORE_DEFINES_SVH
`define TIMER_CORE_DEFINES_SVH

// byte addresses of the register window
`define ADDR_COUNTER_LOW 3'h0
`define ADDR_COUNTER_HIGH 3'h1
`define ADDR_COMPARE_A_LOW 3'h2
`define ADDR_COMPARE_A_HIGH 3'h3
`define ADDR_COMPARE_P_LOW 3'h4
`define ADDR_COMPARE_P_HIGH 3'h5

// clock_select_field codes
`define CLKSEL_SYS_DIV4 3'h0
`define CLKSEL_SYS 3'h1
`define CLKSEL_HI_DIV16 3'h2
`define CLKSEL_HI_DIV64 3'h3
`define CLKSEL_SUB_A 3'h4
`define CLKSEL_SUB_B 3'h5
`define CLKSEL_EXT_RISE 3'h6
`define CLKSEL_EXT_FALL 3'h7

// operating mode codes
`define MODE_COMPARE_OUT 3'h0
`define MODE_CAPTURE 3'h1
`define MODE_PWM 3'h2
`define MODE_SINGLE_PULSE 3'h3
`define MODE_TIMER 3'h4

// compare match output action
`define ACTION_NONE 2'h0
`define ACTION_LOW 2'h1
`define ACTION_HIGH 2'h2
`define ACTION_TOGGLE 2'h3

// capture_edge_select codes
`define CAPTURE_RISE 2'h0
`define CAPTURE_FALL 2'h1
`define CAPTURE_BOTH 2'h2
`define CAPTURE_OFF 2'h3

// prescaler width and the terminal counts of each tap
`define PRESCALE_W 6
`define PRESCALE_DIV4_MASK 6'h03
`define PRESCALE_DIV16_MASK 6'h0F
`define PRESCALE_DIV64_MASK 6'h3F

`define REG_RESET_BYTE 8'h00

`endif

// ---- shared/timer_core_pkg.sv ----
// types of the timer module common core
package timer_core_pkg;
   typedef enum logic {PULSE_IDLE, PULSE_ACTIVE} pulse_state_t;
endpackage : timer_core_pkg

// ---- rtl/pin_sync.sv ----
// three-stage synchroniser with agreement filter and edge pulses for an asynchronous pin
module pin_sync (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic pinIn,
   output logic level,
   output logic rise,
   output logic fall
);
   logic stage1;
   logic stage2;
   logic stage3;
   wire agree = (stage2 == stage3);
   wire next_level = agree ? stage3 : level;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
         level <= 1'b0;
         rise <= 1'b0;
         fall <= 1'b0;
      end else begin
         stage1 <= pinIn;
         stage2 <= stage1;
         stage3 <= stage2;
         level <= next_level;
         rise <= next_level & ~level;
         fall <= ~next_level & level;
      end
   end
endmodule : pin_sync

// ---- rtl/timer_module.sv ----
// timer module common core: counter, comparators A and P, capture, output pins, buffered byte access
`include "timer_core_defines.svh"

// Notes on behaviour
// [R1] counter compared with A and P; match raises interrupt, may clear counter, change pins
// [R2] counter source chosen by clock_select_field: system, high-speed, sub or external clock
// [R3] external clock pin can advance the counter to count outside events
// [R4] separate interrupt outputs for comparator A match and comparator P match
// [R5] external clock pin counts on rising or falling edge as configured
// [R6] single pulse mode starts its pulse on the external clock pin trigger
// [R7] capture on rising, falling or both edges chosen by capture_edge_select
// [R8] periodic type may capture from the external clock pin instead of capture pin
// [R9] compare output mode drives pins high, low or toggles on match
// [R10] PWM waveform comes out on the same output pin pair
// [R11] one edge-aligned PWM channel, software adjusts duty or period
// [R12] pin functions only connect when their pin-function selection is set
// [R13] high bytes accessed directly, low bytes through one shared 8-bit buffer
// [R14] low-byte write fills buffer; high-byte write updates high and copies buffer low (comparators only; counter high writes are ignored)
// [R15] high-byte read returns high and latches low into buffer; low read returns buffer
// [R16] software must write low then high, read high then low
// [R17] match interrupts are single-cycle pulses on the system clock
module timer_module #(
   parameter int CNT_W = 10
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic counterOn,
   input wire logic counterPause,
   input wire logic [2:0] clockSelect,
   input wire logic [2:0] modeSelect,
   input wire logic [1:0] outputAction,
   input wire logic [1:0] captureEdgeSelect,
   input wire logic outInitial,
   input wire logic outPolarity,
   input wire logic clearOnA,
   input wire logic periodOnA,
   input wire logic captureFromExt,
   input wire logic extPinSelected,
   input wire logic capturePinSelected,
   input wire logic outputPinSelected,
   input wire logic [2:0] regAddr,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata,
   input wire logic extClockPin,
   input wire logic capturePin,
   input wire logic subClockPin,
   output logic timerOutPin,
   output logic timerOutPinSecond,
   output logic timerOutEnable,
   output logic pulseBusy,
   output logic irqMatchA,
   output logic irqMatchP
);
   localparam int HI_W = CNT_W - 8;

   if (CNT_W < 9 || CNT_W > 16) begin : g_width_check
      $error("timer_module: CNT_W must lie between 9 and 16");
   end

   // high byte of a counter-wide value, zero above the implemented bits
   function automatic logic [7:0] high_byte(input logic [CNT_W-1:0] v);
      logic [15:0] wide;
      wide = 16'(v);
      return wide[15:8];
   endfunction : high_byte

   // a register with its high byte replaced and the low byte taken from the buffer
   function automatic logic [CNT_W-1:0] join_bytes(input logic [7:0] hi, input logic [7:0] lo);
      return {hi[HI_W-1:0], lo};
   endfunction : join_bytes

   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] compareA;
   logic [CNT_W-1:0] compareP;
   logic [7:0] byteBuffer;
   logic [`PRESCALE_W-1:0] prescale;
   logic onPrev;
   logic outState;
   timer_core_pkg::pulse_state_t pulseState;

   // pin synchronisers
   logic extLevel;
   logic extRise;
   logic extFall;
   logic capLevel;
   logic capRise;
   logic capFall;
   logic subLevel;
   logic subRise;
   logic subFall;

   pin_sync extSync (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .pinIn(extClockPin),
      .level(extLevel),
      .rise(extRise),
      .fall(extFall)
   );

   pin_sync capSync (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .pinIn(capturePin),
      .level(capLevel),
      .rise(capRise),
      .fall(capFall)
   );

   pin_sync subSync (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .pinIn(subClockPin),
      .level(subLevel),
      .rise(subRise),
      .fall(subFall)
   );

   // pin functions are cut off unless their pin-function selection is set
   wire extRiseSel = extRise & extPinSelected; // R12
   wire extFallSel = extFall & extPinSelected; // R12
   wire capRiseSel = capRise & capturePinSelected; // R12
   wire capFallSel = capFall & capturePinSelected; // R12

   // high-speed clock is taken as ref_clk itself, so both ratios share one prescaler
   wire tickDiv4 = (prescale & `PRESCALE_DIV4_MASK) == `PRESCALE_DIV4_MASK;
   wire tickDiv16 = (prescale & `PRESCALE_DIV16_MASK) == `PRESCALE_DIV16_MASK;
   wire tickDiv64 = (prescale & `PRESCALE_DIV64_MASK) == `PRESCALE_DIV64_MASK;

   logic sourceTick;
   always_comb begin
      unique case (clockSelect) // R2
         `CLKSEL_SYS_DIV4: sourceTick = tickDiv4;
         `CLKSEL_SYS: sourceTick = 1'b1;
         `CLKSEL_HI_DIV16: sourceTick = tickDiv16;
         `CLKSEL_HI_DIV64: sourceTick = tickDiv64;
         `CLKSEL_SUB_A, `CLKSEL_SUB_B: sourceTick = subRise;
         `CLKSEL_EXT_RISE: sourceTick = extRiseSel; // R3 R5
         `CLKSEL_EXT_FALL: sourceTick = extFallSel; // R3 R5
      endcase
   end

   wire modeCompare = (modeSelect == `MODE_COMPARE_OUT);
   wire modeCapture = (modeSelect == `MODE_CAPTURE);
   wire modePwm = (modeSelect == `MODE_PWM);
   wire modePulse = (modeSelect == `MODE_SINGLE_PULSE);
   wire modeTimer = (modeSelect == `MODE_TIMER);

   wire onRise = counterOn & ~onPrev;

   // single pulse starts on the on-bit rising or on the external pin's rising edge
   wire pulseTrigger = modePulse & counterOn & (onRise | extRiseSel); // R6
   wire pulseRunning = (pulseState == timer_core_pkg::PULSE_ACTIVE);

   wire countEnable = counterOn & ~counterPause & (~modePulse | pulseRunning);
   wire countStep = countEnable & sourceTick & ~onRise;
   wire [CNT_W-1:0] stepValue = CNT_W'(count + 1'b1);

   // a match is judged on the value the counter holds, so the period is compare + 1 ticks
   // P at zero stands for the wrap from all ones, i.e. plain overflow
   wire [CNT_W-1:0] pLimit = (compareP == '0) ? '1 : compareP;
   wire hitA = countStep & (count == compareA) & ~modeCapture; // R1
   wire hitP = countStep & (count == pLimit); // R1

   // in PWM the period comparator always clears; elsewhere software picks the clearing comparator
   wire clearSelA = modePwm ? periodOnA : clearOnA; // R11
   wire clearNow = clearSelA ? hitA : hitP; // R1

   // capture source: dedicated pin, or the external clock pin on the periodic type
   wire srcRise = captureFromExt ? extRiseSel : capRiseSel; // R8
   wire srcFall = captureFromExt ? extFallSel : capFallSel; // R8
   logic captureEdge;
   always_comb begin
      unique case (captureEdgeSelect) // R7
         `CAPTURE_RISE: captureEdge = srcRise;
         `CAPTURE_FALL: captureEdge = srcFall;
         `CAPTURE_BOTH: captureEdge = srcRise | srcFall;
         `CAPTURE_OFF: captureEdge = 1'b0;
      endcase
   end
   wire captureHit = modeCapture & counterOn & captureEdge;

   wire [CNT_W-1:0] next_count = onRise ? '0 : (clearNow ? '0 : (countStep ? stepValue : count));

   // register window decode
   wire wrCompAHigh = regWrite & (regAddr == `ADDR_COMPARE_A_HIGH);
   wire wrCompPHigh = regWrite & (regAddr == `ADDR_COMPARE_P_HIGH);
   wire wrLow = regWrite & ((regAddr == `ADDR_COMPARE_A_LOW) | (regAddr == `ADDR_COMPARE_P_LOW) |
                            (regAddr == `ADDR_COUNTER_LOW));
   wire rdCntHigh = regRead & (regAddr == `ADDR_COUNTER_HIGH);
   wire rdCompAHigh = regRead & (regAddr == `ADDR_COMPARE_A_HIGH);
   wire rdCompPHigh = regRead & (regAddr == `ADDR_COMPARE_P_HIGH);
   wire rdLow = regRead & ((regAddr == `ADDR_COMPARE_A_LOW) | (regAddr == `ADDR_COMPARE_P_LOW) |
                           (regAddr == `ADDR_COUNTER_LOW));

   // capture wins over a software write to comparator A landing in the same cycle
   wire [CNT_W-1:0] next_compareA = captureHit ? count :
                                    (wrCompAHigh ? join_bytes(regWdata, byteBuffer) : compareA); // R14
   wire [CNT_W-1:0] next_compareP = wrCompPHigh ? join_bytes(regWdata, byteBuffer) : compareP; // R14

   // one shared buffer: low writes fill it, high reads refill it from the low byte
   wire [7:0] next_byteBuffer = wrLow ? regWdata : // R13 R14
                                rdCntHigh ? count[7:0] : // R15
                                rdCompAHigh ? compareA[7:0] : // R15
                                rdCompPHigh ? compareP[7:0] : byteBuffer; // R15

   wire [7:0] next_regRdata = rdLow ? byteBuffer : // R15
                              rdCntHigh ? high_byte(count) : // R13
                              rdCompAHigh ? high_byte(compareA) : // R13
                              rdCompPHigh ? high_byte(compareP) : regRdata;

   // output state per mode
   logic actionResult;
   always_comb begin
      unique case (outputAction) // R9
         `ACTION_NONE: actionResult = outState;
         `ACTION_LOW: actionResult = 1'b0;
         `ACTION_HIGH: actionResult = 1'b1;
         `ACTION_TOGGLE: actionResult = ~outState;
      endcase
   end

   // edge aligned: active from period start until the duty comparator value
   wire [CNT_W-1:0] dutyValue = periodOnA ? compareP : compareA; // R11
   wire pwmActive = counterOn & (next_count < dutyValue); // R10 R11

   logic next_outState;
   always_comb begin
      next_outState = outState;
      if (modePwm) begin
         next_outState = pwmActive; // R10
      end else if (onRise) begin
         next_outState = outInitial;
      end else if (modeCompare & hitA) begin
         next_outState = actionResult; // R9
      end else if (modePulse) begin
         if (pulseTrigger) begin
            next_outState = 1'b1; // R6
         end else if (hitA) begin
            next_outState = 1'b0;
         end
      end
   end

   timer_core_pkg::pulse_state_t next_pulseState;
   always_comb begin
      next_pulseState = pulseState;
      unique case (pulseState)
         timer_core_pkg::PULSE_IDLE: begin
            if (pulseTrigger) begin
               next_pulseState = timer_core_pkg::PULSE_ACTIVE; // R6
            end
         end
         timer_core_pkg::PULSE_ACTIVE: begin
            if (hitA | ~counterOn | ~modePulse) begin
               next_pulseState = timer_core_pkg::PULSE_IDLE;
            end
         end
      endcase
   end

   wire pinsUsed = modeCompare | modePwm | modePulse;
   wire next_pinLevel = next_outState ^ outPolarity;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         prescale <= '0;
         onPrev <= 1'b0;
         count <= '0;
         compareA <= '0;
         compareP <= '0;
         byteBuffer <= `REG_RESET_BYTE;
         regRdata <= `REG_RESET_BYTE;
      end else begin
         prescale <= `PRESCALE_W'(prescale + 1'b1);
         onPrev <= counterOn;
         count <= next_count; // R1
         compareA <= next_compareA;
         compareP <= next_compareP;
         byteBuffer <= next_byteBuffer;
         regRdata <= next_regRdata;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         outState <= 1'b0;
         pulseState <= timer_core_pkg::PULSE_IDLE;
         pulseBusy <= 1'b0;
         timerOutPin <= 1'b0;
         timerOutPinSecond <= 1'b0;
         timerOutEnable <= 1'b0;
      end else begin
         outState <= next_outState;
         pulseState <= next_pulseState;
         pulseBusy <= (next_pulseState == timer_core_pkg::PULSE_ACTIVE);
         timerOutPin <= outputPinSelected & next_pinLevel; // R10 R12
         timerOutPinSecond <= outputPinSelected & ~next_pinLevel; // R10 R12
         timerOutEnable <= outputPinSelected & pinsUsed; // R12
      end
   end

   // every event is already on ref_clk, so one registered cycle gives a clean pulse
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         irqMatchA <= 1'b0;
         irqMatchP <= 1'b0;
      end else begin
         irqMatchA <= hitA | captureHit; // R4 R17
         irqMatchP <= hitP; // R4 R17
      end
   end

   // timer mode, like capture mode, keeps timerOutEnable low; the pin levels are unused in every mode
   wire unusedLevels = extLevel ^ capLevel ^ subLevel ^ subFall ^ modeTimer;
endmodule : timer_module

// ---- bench/pin_partner.sv ----
// far-side model driving the external clock, capture and sub clock pins
module pin_partner (
   input wire logic ref_clk,
   output logic extClockPin,
   output logic capturePin,
   output logic subClockPin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      extClockPin = 1'b0;
      capturePin = 1'b0;
      subClockPin = 1'b0;
      // sub clock runs free at ref_clk/32, well below the filter limit
      forever begin
         repeat (16) @(negedge ref_clk);
         subClockPin = ~subClockPin;
      end
   end
   // the external pin stands still between calls
   task automatic setExt(input logic v);
      @(negedge ref_clk);
      extClockPin = v;
   endtask : setExt
   task automatic setCap(input logic v);
      @(negedge ref_clk);
      capturePin = v;
   endtask : setCap
endmodule : pin_partner

// ---- bench/timer_module_monitor.sv ----
// port assertions for the timer module
`include "timer_core_defines.svh"
module timer_module_monitor #(
   parameter int CNT_W = 10
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic counterOn,
   input wire logic [2:0] clockSelect,
   input wire logic [2:0] modeSelect,
   input wire logic outputPinSelected,
   input wire logic [2:0] regAddr,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regWdata,
   input wire logic [7:0] regRdata,
   input wire logic timerOutPin,
   input wire logic timerOutPinSecond,
   input wire logic timerOutEnable,
   input wire logic pulseBusy,
   input wire logic irqMatchA,
   input wire logic irqMatchP
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   localparam logic [7:0] HIGH_MASK = 8'((1 << (CNT_W - 8)) - 1);
   irq_a_pulse_a: assert property (irqMatchA && clockSelect == `CLKSEL_SYS_DIV4 |=> !irqMatchA)
      else $error("irqMatchA wider than one cycle");
   irq_p_pulse_a: assert property (irqMatchP |=> !irqMatchP)
      else $error("irqMatchP wider than one cycle");
   pin_pair_a: assert property ($past(outputPinSelected) && $past(arst_n) |-> timerOutPinSecond == !timerOutPin)
      else $error("output pins not complementary");
   pin_gated_a: assert property (!$past(outputPinSelected) |-> !(timerOutPin || timerOutPinSecond || timerOutEnable))
      else $error("unselected output pin driven");
   timer_quiet_a: assert property ($past(modeSelect) == `MODE_TIMER |-> !timerOutEnable)
      else $error("output enabled in timer mode");
   unmapped_read_a: assert property (regRead && regAddr > `ADDR_COMPARE_P_HIGH |=> $stable(regRdata))
      else $error("unmapped read changed read data");
   high_reread_a: assert property ((regRead && !regWrite && regAddr == `ADDR_COMPARE_A_HIGH
      && modeSelect != `MODE_CAPTURE)[*2] |=> $stable(regRdata))
      else $error("high byte reread differs");
   write_pair_a: assert property ((regWrite && regAddr == `ADDR_COMPARE_A_HIGH && modeSelect != `MODE_CAPTURE)
      ##1 (regRead && !regWrite && regAddr == `ADDR_COMPARE_A_HIGH)
      |=> regRdata == ($past(regWdata, 2) & HIGH_MASK))
      else $error("high byte write not read back");
   match_needs_on_a: assert property (irqMatchP && modeSelect != `MODE_SINGLE_PULSE |-> $past(counterOn))
      else $error("P match while counter off");
   cover property (irqMatchA);
   cover property (irqMatchP);
   cover property ($rose(pulseBusy));
endmodule : timer_module_monitor
bind timer_module timer_module_monitor #(.CNT_W(CNT_W)) mon (.ref_clk(ref_clk), .arst_n(arst_n),
   .counterOn(counterOn), .clockSelect(clockSelect), .modeSelect(modeSelect),
   .outputPinSelected(outputPinSelected), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
   .regWdata(regWdata), .regRdata(regRdata), .timerOutPin(timerOutPin), .timerOutPinSecond(timerOutPinSecond),
   .timerOutEnable(timerOutEnable), .pulseBusy(pulseBusy), .irqMatchA(irqMatchA), .irqMatchP(irqMatchP));

// ---- bench/timer_module_test.sv ----
// self-checking bench for the timer module
`include "timer_core_defines.svh"
module timer_module_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, arst_n, counterOn, counterPause, outInitial, outPolarity, clearOnA, periodOnA, captureFromExt;
   logic extPinSelected, capturePinSelected, outputPinSelected, regWrite, regRead, extClockPin, capturePin;
   logic [2:0] clockSelect, modeSelect, regAddr;
   logic [1:0] outputAction, captureEdgeSelect;
   logic [7:0] regWdata, regRdata;
   logic subClockPin, timerOutPin, timerOutPinSecond, timerOutEnable, pulseBusy, irqMatchA, irqMatchP;
   int miscompares = 0;
   int total_checks = 0;
   timer_module uut (.ref_clk(ref_clk), .arst_n(arst_n), .counterOn(counterOn), .counterPause(counterPause),
      .clockSelect(clockSelect), .modeSelect(modeSelect), .outputAction(outputAction),
      .captureEdgeSelect(captureEdgeSelect), .outInitial(outInitial), .outPolarity(outPolarity),
      .clearOnA(clearOnA), .periodOnA(periodOnA), .captureFromExt(captureFromExt),
      .extPinSelected(extPinSelected), .capturePinSelected(capturePinSelected),
      .outputPinSelected(outputPinSelected), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
      .regWdata(regWdata), .regRdata(regRdata), .extClockPin(extClockPin), .capturePin(capturePin),
      .subClockPin(subClockPin), .timerOutPin(timerOutPin), .timerOutPinSecond(timerOutPinSecond),
      .timerOutEnable(timerOutEnable), .pulseBusy(pulseBusy), .irqMatchA(irqMatchA), .irqMatchP(irqMatchP));
   pin_partner pins (.ref_clk(ref_clk), .extClockPin(extClockPin), .capturePin(capturePin),
      .subClockPin(subClockPin));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check
   // strobes stay up across back-to-back accesses and drop when idle cycles begin
   task automatic cyc(input int n);
      regWrite = 1'b0;
      regRead = 1'b0;
      repeat (n) @(negedge ref_clk);
   endtask : cyc
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      regAddr = a;
      regWdata = d;
      regRead = 1'b0;
      regWrite = 1'b1;
      @(negedge ref_clk);
   endtask : wr
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      regAddr = a;
      regWrite = 1'b0;
      regRead = 1'b1;
      @(negedge ref_clk);
      d = regRdata;
   endtask : rd
   // low byte first so the buffer holds it when the high byte lands
   task automatic wrPair(input logic [2:0] a, input logic [15:0] v);
      wr(a, v[7:0]);
      wr(3'(a + 3'h1), v[15:8]);
   endtask : wrPair
   task automatic restart();
      counterOn = 1'b0;
      cyc(1);
      counterOn = 1'b1;
      cyc(1);
   endtask : restart
   function automatic logic pick(input int w);
      return (w == 0) ? irqMatchA : (w == 1) ? irqMatchP : pulseBusy;
   endfunction : pick
   task automatic waitFor(input int w, input logic v, input int lim, output int n);
      n = 0;
      while (pick(w) !== v && n < lim) begin
         cyc(1);
         n++;
      end
   endtask : waitFor
   task automatic t_regs();
      logic [7:0] d;
      wr(`ADDR_COMPARE_A_LOW, 8'h55);
      wr(`ADDR_COMPARE_P_LOW, 8'h66);
      wrPair(`ADDR_COMPARE_A_LOW, 16'h0155);
      rd(`ADDR_COMPARE_A_HIGH, d);
      check(d, 8'h01);
      wr(`ADDR_COUNTER_LOW, 8'h77);
      wr(`ADDR_COUNTER_HIGH, 8'h03);
      rd(`ADDR_COUNTER_HIGH, d);
      check(d, 8'h00);
      rd(`ADDR_COMPARE_A_HIGH, d);
      rd(`ADDR_COMPARE_A_HIGH, d);
      rd(3'h6, d);
      check(d, 8'h01);
      rd(`ADDR_COMPARE_A_LOW, d);
      check(d, 8'h55);
      $display("test regs done");
   endtask : t_regs
   task automatic t_clocks();
      logic [2:0] sel [5] = '{`CLKSEL_SYS, `CLKSEL_SYS_DIV4, `CLKSEL_HI_DIV16, `CLKSEL_HI_DIV64, `CLKSEL_SUB_A};
      int gap [5] = '{1, 7, 31, 127, 63};
      int n;
      wrPair(`ADDR_COMPARE_A_LOW, 16'h0001);
      for (int i = 0; i < 6; i++) begin
         clockSelect = (i < 5) ? sel[i] : `CLKSEL_SYS;
         clearOnA = (i < 5);
         if (i == 5) wrPair(`ADDR_COMPARE_P_LOW, 16'h0005);
         restart();
         waitFor(i / 5, 1'b1, 300, n);
         cyc(1);
         waitFor(i / 5, 1'b1, 300, n);
         check(16'(n), (i < 5) ? 16'(gap[i]) : 16'h0005);
         cyc(1);
         check(16'(pick(i / 5)), 16'h0000);
      end
      $display("test clocks done");
   endtask : t_clocks
   task automatic t_ext();
      logic [7:0] d;
      clearOnA = 1'b1;
      extPinSelected = 1'b1;
      wrPair(`ADDR_COMPARE_A_LOW, 16'h03FF);
      for (int i = 0; i < 3; i++) begin
         clockSelect = i[0] ? `CLKSEL_EXT_FALL : `CLKSEL_EXT_RISE;
         extPinSelected = (i < 2);
         if (i < 2) restart();
         cyc(1);
         pins.setExt(1'b1);
         cyc(10);
         rd(`ADDR_COUNTER_HIGH, d);
         rd(`ADDR_COUNTER_LOW, d);
         check(d, (i == 1) ? 8'h00 : 8'h01);
         cyc(1);
         pins.setExt(1'b0);
         cyc(10);
         rd(`ADDR_COUNTER_HIGH, d);
         rd(`ADDR_COUNTER_LOW, d);
         check(d, 8'h01);
      end
      $display("test ext done");
   endtask : t_ext
   task automatic t_capture();
      logic [1:0] es [4] = '{`CAPTURE_RISE, `CAPTURE_FALL, `CAPTURE_BOTH, `CAPTURE_OFF};
      logic [7:0] exp = 8'h39;
      int n;
      modeSelect = `MODE_CAPTURE;
      capturePinSelected = 1'b1;
      clockSelect = `CLKSEL_SYS;
      restart();
      for (int k = 0; k < 8; k++) begin
         captureEdgeSelect = es[k / 2];
         pins.setCap(~k[0]);
         waitFor(0, 1'b1, 12, n);
         check(16'(n < 12), 16'(exp[k]));
         cyc(8);
      end
      // the external clock pin as the alternative capture source
      captureFromExt = 1'b1;
      extPinSelected = 1'b1;
      captureEdgeSelect = `CAPTURE_RISE;
      pins.setExt(1'b1);
      waitFor(0, 1'b1, 12, n);
      check(16'(n < 12), 16'h0001);
      captureFromExt = 1'b0;
      pins.setExt(1'b0);
      cyc(8);
      $display("test capture done");
   endtask : t_capture
   task automatic t_outputs();
      logic [1:0] act [4] = '{`ACTION_HIGH, `ACTION_LOW, `ACTION_TOGGLE, `ACTION_NONE};
      logic [3:0] pinExp = 4'h5;
      int n;
      int highs;
      modeSelect = `MODE_COMPARE_OUT;
      outputPinSelected = 1'b1;
      wrPair(`ADDR_COMPARE_A_LOW, 16'h0003);
      for (int i = 0; i < 4; i++) begin
         outputAction = act[i];
         outInitial = (act[i] == `ACTION_LOW);
         restart();
         waitFor(0, 1'b1, 20, n);
         cyc(2);
         check({timerOutEnable, timerOutPin}, {1'b1, pinExp[i]});
      end
      // period by A of 8 counts, duty below P=3: 6 highs in two periods
      modeSelect = `MODE_PWM;
      periodOnA = 1'b1;
      wrPair(`ADDR_COMPARE_A_LOW, 16'h0007);
      wrPair(`ADDR_COMPARE_P_LOW, 16'h0003);
      restart();
      cyc(4);
      highs = 0;
      repeat (16) begin
         cyc(1);
         highs += int'(timerOutPin === 1'b1);
      end
      check(16'(highs), 16'h0006);
      $display("test outputs done");
   endtask : t_outputs
   task automatic t_pulse();
      int n;
      modeSelect = `MODE_SINGLE_PULSE;
      extPinSelected = 1'b1;
      clockSelect = `CLKSEL_SYS;
      wrPair(`ADDR_COMPARE_A_LOW, 16'h0005);
      restart();
      waitFor(2, 1'b0, 40, n);
      pins.setExt(1'b1);
      waitFor(2, 1'b1, 12, n);
      check(16'(n < 12), 16'h0001);
      cyc(1);
      check(timerOutPin, 1'b1);
      waitFor(2, 1'b0, 20, n);
      check(16'(n < 20), 16'h0001);
      $display("test pulse done");
   endtask : t_pulse
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   // the tests need well under 8000 cycles
   initial begin
      #60000;
      miscompares++;
      print_verdict();
   end
   initial begin
      {counterOn, counterPause, outInitial, outPolarity, clearOnA, periodOnA, captureFromExt} = '0;
      {extPinSelected, capturePinSelected, outputPinSelected, regWrite, regRead} = '0;
      {clockSelect, regAddr, outputAction, captureEdgeSelect, regWdata} = '0;
      modeSelect = `MODE_TIMER;
      arst_n = 1'b0;
      repeat (12) @(negedge ref_clk);
      arst_n = 1'b1;
      check({irqMatchA, irqMatchP, timerOutPin, timerOutEnable, regRdata}, 16'h0000);
      t_regs();
      t_clocks();
      t_ext();
      t_capture();
      t_outputs();
      t_pulse();
      print_verdict();
   end
endmodule : timer_module_test
